//--- sbsi_host_model.sv
/* Host side of the memory pins, one beat a clock.
   Assumes the bench calls beat once per clock. */
module sbsi_host_model (
  input  wire logic            clock_i,
  output sbsi_pkg::sbsi_pins_t pins_o,
  output logic [31:0]          data_o,
  output logic [3:0]           parity_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {pins_o, data_o, parity_o} = '1;
  task automatic beat(input sbsi_pkg::sbsi_pins_t p,
    input logic [35:0] d);
    @(posedge clock_i);
    #1;
    pins_o = p;
    // Released lines toggle so stale data cannot pass
    {data_o, parity_o} = p.write_en_n ? ~{data_o, parity_o} : d;
  endtask
endmodule // sbsi_host_model

//--- sbsi_input_ctrl.sv
/*
 * Input qualification of a pipelined burst static memory: pin sampling,
 * chip select, clock enable, load/advance of the burst counter, byte
 * lane write gating. Assumes pins come from another domain and are
 * synchronised here; the array behind it takes access_o each cycle.
 */
// Notes on behaviour
// - The address and its two burst bits are captured at the clock edge.
// - Byte write selects are active low and need an active write enable.
// - Each lane select gates one data byte and its own parity bit.
// - Write enable is sampled only when clock enable is low.
// - Advance high with clock enable low steps the burst counter unless the last load deselected.
// - With clock enable high every synchronous input except data and parity is ignored.
// - Order strap high gives interleaved order, low gives linear.
// - Selected only with first and third selects low, second high.
// - Clock enable high holds address, op and select state rather than deselecting.
module sbsi_input_ctrl (
  input  wire logic                      clock_i,
  input  wire logic                      rst_i,
  input  wire sbsi_pkg::sbsi_pins_t      pins_i,
  input  wire logic [sbsi_pkg::LANES*sbsi_pkg::BYTE_W-1:0] data_i,
  input  wire logic [sbsi_pkg::LANES-1:0] parity_i,
  output logic                           selected_o,
  output sbsi_pkg::sbsi_access_t         access_o
);

  typedef struct packed {
    sbsi_pkg::sbsi_pins_t sync1;
    sbsi_pkg::sbsi_pins_t sync2;
    logic [sbsi_pkg::LANES*sbsi_pkg::BYTE_W-1:0] d_sync1;
    logic [sbsi_pkg::LANES*sbsi_pkg::BYTE_W-1:0] d_sync2;
    logic [sbsi_pkg::LANES-1:0] p_sync1;
    logic [sbsi_pkg::LANES-1:0] p_sync2;
    logic [sbsi_pkg::ADDR_W-1:0]  base;
    logic [sbsi_pkg::BURST_W-1:0] start;
    logic [sbsi_pkg::BURST_W-1:0] step;
    logic [sbsi_pkg::LANES-1:0]   lane_sel;
    sbsi_pkg::sbsi_op_t           op;
    logic                         order;
    logic                         selected;
    sbsi_pkg::sbsi_access_t       access;
  } sbsi_state_t;

  sbsi_state_t state_q;
  sbsi_state_t state_d;

  // Burst offset from start and step; interleave is an XOR, linear an add
  function automatic logic [sbsi_pkg::BURST_W-1:0] burst_offset(
    input logic [sbsi_pkg::BURST_W-1:0] start,
    input logic [sbsi_pkg::BURST_W-1:0] step,
    input logic                         order
  );
    if (order == 1'b1) begin
      return start ^ step;
    end
    return start + step;
  endfunction

  function automatic logic chip_selected(input sbsi_pkg::sbsi_pins_t p);
    return !p.chip_sel_first_n && p.chip_sel_second
      && !p.chip_sel_third_n;
  endfunction

  logic [sbsi_pkg::BURST_W-1:0] next_step;
  logic [sbsi_pkg::BURST_W-1:0] offset;
  sbsi_pkg::sbsi_pins_t         s;

  always_comb begin
    state_d = state_q;
    s = state_q.sync2;
    next_step = sbsi_pkg::BURST_ZERO;
    offset = sbsi_pkg::BURST_ZERO;
    // Pins cross two flops before anything reads them
    state_d.sync1 = pins_i;
    state_d.sync2 = state_q.sync1;
    state_d.d_sync1 = data_i;
    state_d.d_sync2 = state_q.d_sync1;
    state_d.p_sync1 = parity_i;
    state_d.p_sync2 = state_q.p_sync1;
    // Clock enable high: address, op and burst state frozen, lane writes off, data and parity still pass
    if (!s.clock_enable_n) begin
      if (!s.advance_or_load) begin
        state_d.selected = chip_selected(s);
        state_d.base = s.addr;
        state_d.start = s.addr[sbsi_pkg::BURST_W-1:0];
        state_d.step = sbsi_pkg::BURST_ZERO;
        if (!chip_selected(s)) begin
          state_d.op = sbsi_pkg::SBSI_IDLE;
        end else if (!s.write_en_n) begin
          state_d.op = sbsi_pkg::SBSI_WRITE;
        end else begin
          state_d.op = sbsi_pkg::SBSI_READ;
        end
      end else if (state_q.op != sbsi_pkg::SBSI_IDLE) begin
        // Advance keeps the op; lane selects and order strap are refreshed
        state_d.step = state_q.step + sbsi_pkg::BURST_ONE;
      end
      state_d.lane_sel = ~s.lane_sel_n;
      // Strap taken only on live edges so a held cycle keeps its address
      state_d.order = s.burst_order;
    end
    next_step = state_d.step;
    offset = burst_offset(state_d.start, next_step, state_d.order);
    state_d.access.addr = {state_d.base[sbsi_pkg::ADDR_W-1:sbsi_pkg::BURST_W],
                           offset};
    state_d.access.op = state_d.op;
    state_d.access.lane_we = sbsi_pkg::LANES_OFF;
    if (!s.clock_enable_n && state_d.op == sbsi_pkg::SBSI_WRITE) begin
      state_d.access.lane_we = state_d.lane_sel;
    end
    // Data and parity of a lane travel under the same select
    state_d.access.data = state_q.d_sync2;
    state_d.access.parity = state_q.p_sync2;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign selected_o = state_q.selected;
  assign access_o   = state_q.access;

endmodule // sbsi_input_ctrl

//--- sbsi_monitor.sv
/* Port checker of sbsi_input_ctrl, bound below.
   Assumes pins idle with clock enable high in reset. */
module sbsi_monitor (
  input wire logic                   clock_i,
  input wire logic                   rst_i,
  input wire sbsi_pkg::sbsi_pins_t   pins_i,
  input wire logic                   selected_o,
  input wire sbsi_pkg::sbsi_access_t access_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sbsi_pkg::sbsi_pins_t p1, p2, p3;
  logic                 ld, ad, sl;
  logic [1:0]           lo;
  // Same three flops as the sync path
  always_ff @(posedge clock_i) begin
    p1 <= pins_i;
    p2 <= p1;
    p3 <= p2;
  end
  assign ld = !p3.clock_enable_n && !p3.advance_or_load;
  assign ad = !p3.clock_enable_n && p3.advance_or_load;
  assign sl = !p3.chip_sel_first_n && p3.chip_sel_second
    && !p3.chip_sel_third_n;
  assign lo = access_o.addr[1:0];
  a_write_lanes: assert property (ld && sl && !p3.write_en_n |->
    access_o.lane_we == ~p3.lane_sel_n) else $error("lanes");
  a_load_op: assert property (ld && sl |-> access_o.op ==
    (p3.write_en_n ? sbsi_pkg::SBSI_READ : sbsi_pkg::SBSI_WRITE))
    else $error("op");
  a_load_addr: assert property (ld && sl |-> selected_o &&
    access_o.addr == p3.addr) else $error("addr");
  a_desel_flag: assert property (ld && !sl |-> !selected_o)
    else $error("deselect");
  a_cen_hold: assert property (p3.clock_enable_n |->
    $stable(access_o.addr) && access_o.lane_we == 4'h0) else $error("hold");
  a_lane_op: assert property (|access_o.lane_we |->
    access_o.op == sbsi_pkg::SBSI_WRITE) else $error("lane op");
  a_upper_fixed: assert property (ad && $past(selected_o) |->
    $stable(access_o.addr[17:2])) else $error("upper");
  a_linear_step: assert property (ad && $past(selected_o) &&
    !p3.burst_order |-> lo == $past(lo) + 2'h1) else $error("step");
endmodule // sbsi_monitor
bind sbsi_input_ctrl sbsi_monitor mon_u (.clock_i(clock_i), .rst_i(rst_i),
  .pins_i(pins_i), .selected_o(selected_o), .access_o(access_o));

//--- sbsi_pkg.sv
/*
 * Package for the burst memory input qualification block: widths,
 * burst order codes and the carrier structs of sampled pins.
 * Assumes a single 100 MHz clock and no register bus.
 */
package sbsi_pkg;

  localparam int ADDR_W  = 18;
  localparam int LANES   = 4;
  localparam int BYTE_W  = 8;
  localparam int BURST_W = 2;

  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;
  localparam logic [LANES-1:0]   LANES_OFF  = 4'h0;
  localparam logic [ADDR_W-1:0]  ADDR_ZERO  = 18'h00000;

  typedef enum logic {
    SBSI_ORDER_LINEAR,
    SBSI_ORDER_INTERLEAVED
  } sbsi_order_t;

  typedef enum logic [1:0] {
    SBSI_IDLE,
    SBSI_READ,
    SBSI_WRITE
  } sbsi_op_t;

  // Raw pin sample, one set per clock
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lane_sel_n;
    logic              write_en_n;
    logic              advance_or_load;
    logic              clock_enable_n;
    logic              chip_sel_first_n;
    logic              chip_sel_second;
    logic              chip_sel_third_n;
    logic              burst_order;
  } sbsi_pins_t;

  // Qualified access presented to the array
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lane_we;
    logic [LANES*BYTE_W-1:0] data;
    logic [LANES-1:0]  parity;
    sbsi_op_t          op;
  } sbsi_access_t;

endpackage : sbsi_pkg

//--- tb_sync_burst_sram_input_control.sv
/* Bench: host model feeds the input block; notes are
   checked when the three-flop path delivers them. */
module tb_sync_burst_sram_input_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clock_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   drain = 1'b0;
  logic                   sel_o;
  logic [31:0]            r, dw;
  logic [3:0]             pw;
  logic [35:0]            dp;
  logic [1:0]             st, cnt;
  sbsi_pkg::sbsi_pins_t   p, pins;
  sbsi_pkg::sbsi_access_t acc, e, g, q[$];
  int                     n_mismatch = 0, cmp_count = 0, cyc = 0;
  always #5 clock_i = ~clock_i;
  sbsi_host_model host (.clock_i(clock_i), .pins_o(pins), .data_o(dw),
    .parity_o(pw));
  sbsi_input_ctrl dut_u (.clock_i(clock_i), .rst_i(rst_i), .pins_i(pins),
    .data_i(dw), .parity_i(pw), .selected_o(sel_o), .access_o(acc));
  task automatic step(input logic o, input logic c, input logic f);
    r = $urandom;
    dp = {$urandom, r[29:26]};
    c &= !f;
    p = {r[17:0], r[21:18], r[22], !f && e.op != sbsi_pkg::SBSI_IDLE &&
      r[23], c, r[24] & r[25], 1'b1, 1'b0, o};
    if (p.advance_or_load) p.write_en_n = e.op != sbsi_pkg::SBSI_WRITE;
    e.lane_we = 4'h0;
    if (!c && !p.advance_or_load) begin
      e.op = p.chip_sel_first_n ? sbsi_pkg::SBSI_IDLE : p.write_en_n ?
        sbsi_pkg::SBSI_READ : sbsi_pkg::SBSI_WRITE;
      {e.addr, st, cnt} = {p.addr, p.addr[1:0], 2'h0};
    end else if (!c) begin
      cnt++;
      e.addr[1:0] = o ? st ^ cnt : e.addr[1:0] + 2'h1;
    end
    if (!c && e.op == sbsi_pkg::SBSI_WRITE) e.lane_we = ~p.lane_sel_n;
    {e.data, e.parity} = dp;
    q.push_back(e);
    host.beat(p, dp);
  endtask
  always @(negedge clock_i) if (q.size() == 5 || (drain && q.size() != 0))
  begin
    g = q.pop_front();
    cmp_count++;
    if (acc.lane_we !== g.lane_we || acc.op !== g.op ||
        sel_o !== (g.op != sbsi_pkg::SBSI_IDLE) ||
        (g.op != sbsi_pkg::SBSI_IDLE && acc.addr !== g.addr) ||
        (g.lane_we != 4'h0 && {acc.data, acc.parity} !==
        {g.data, g.parity})) begin
      $display("unexpected access_o exp %h got %h", g, acc);
      n_mismatch++;
    end
  end
  task automatic final_report;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clock_i) if (++cyc == 500) begin
    n_mismatch++;
    final_report();
  end
  initial begin
    r = $urandom(32'h672eb2ec);
    e = '0;
    repeat (10) @(posedge clock_i);
    #1 rst_i = 1'b0;
    // Strap moves only during held beats, then a fresh load
    for (int i = 0; i < 85; i++)
      step(i >= 40, i % 40 < 4 || i > 79 || r[31] & r[30], i % 40 == 4);
    // Last notes are still in the three-flop path
    drain = 1'b1;
    repeat (4) @(negedge clock_i);
    final_report();
  end
endmodule // tb_sync_burst_sram_input_control
